// >>> dpdc_pkg.sv
package dpdc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CSR    = 8'h00;
   localparam logic [7:0] ADDR_IER    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_EVENT  = 8'h0C;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int PSEL_LSB  = 10;
   localparam int PSEL_W    = 6;
   localparam int GIE_BIT   = 0;
   localparam int NONMASKABLE_INTERRUPT_ALLOW_BIT  = 1;
   localparam logic [31:0] CSR_RESET = 32'h0000_0000;
   localparam logic [31:0] IER_RESET = 32'h0000_0000;
   localparam logic [31:0] CSR_WMASK = 32'h0000_FC01;
   localparam logic [31:0] IER_WMASK = 32'h0000_0002;

   // Select codes
   localparam logic [5:0] SEL_PD1_EN  = 6'h09;
   localparam logic [5:0] SEL_PD1_ANY = 6'h11;
   localparam logic [5:0] SEL_PD2     = 6'h1A;
   localparam logic [5:0] SEL_PD3     = 6'h1C;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 50;
   localparam int ENTRY_DELAY_CY = 9;
   localparam int RELOCK_US      = 75;
   localparam int RELOCK_CY      = (RELOCK_US * 1000) / CLK_PERIOD_NS;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      ST_RUN     = 3'b000,
      ST_ENTRY   = 3'b001,
      ST_GATED   = 3'b010,
      ST_SERVICE = 3'b011,
      ST_PLL_OUT = 3'b100,
      ST_PLL_IN  = 3'b101,
      ST_RELOCK  = 3'b110
   } dpdc_state_e;

   typedef struct packed
   {
      logic cpu_clk_en;
      logic irq_logic_clk_en;
      logic dma_clk_en;
      logic pll_out_en;
      logic pll_in_en;
      logic io_freeze;
      logic emu_spin_idle;
   } dpdc_ctrl_s;

endpackage

// >>> dpdc_power_down.sv
`timescale 1ns/100ps
module dpdc_power_down
   import dpdc_pkg::*;
#(
   parameter int RELOCK_CYCLES = RELOCK_CY
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt side
   input  wire logic        irq_enabled,
   input  wire logic        irq_nonenabled,
   input  wire logic        isr_done,
   // Emulator
   input  wire logic        emu_attached,
   input  wire logic        emu_reset,
   input  wire logic        emu_exec_cmd,
   // Power control outputs
   output dpdc_ctrl_s       ctrl,
   output logic             isr_request,
   output logic             resume_pulse,
   output logic             pll_relocking
);

   initial
   begin
      if (RELOCK_CYCLES < 1)
      begin
         $error("RELOCK_CYCLES must be at least 1");
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] csr_reg;
   logic [31:0] ier_reg;
   dpdc_state_e state_reg, state_next;
   logic [3:0]  entry_cnt_reg;
   logic [31:0] relock_cnt_reg;
   logic        emu_mask_reg;
   logic        wake_any_reg;
   logic        spin_seen_reg;
   logic        aw_held_reg, w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   dpdc_ctrl_s  ctrl_reg;
   logic        isr_reg;
   logic        resume_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire         do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire         wr_csr    = do_write && (aw_addr_reg == ADDR_CSR);
   wire         wr_ier    = do_write && (aw_addr_reg == ADDR_IER);
   wire         wr_known  = wr_csr || wr_ier;
   wire [31:0]  strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                             {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0]  csr_wm    = strb_mask & CSR_WMASK;
   wire [31:0]  ier_wm    = strb_mask & IER_WMASK;
   wire         rd_take   = s_axi_arvalid && !s_axi_rvalid;
   wire [5:0]   psel      = csr_reg[PSEL_LSB +: PSEL_W];
   wire         global_interrupt_allow       = csr_reg[GIE_BIT];
   wire         nonmaskable_interrupt_allow      = ier_reg[NONMASKABLE_INTERRUPT_ALLOW_BIT];
   wire [31:0]  status_w  = {24'h00_0000, emu_mask_reg, pll_relocking,
                             spin_seen_reg, 2'h0, state_reg};
   wire         rd_known  = (s_axi_araddr == ADDR_CSR) ||
                            (s_axi_araddr == ADDR_IER) ||
                            (s_axi_araddr == ADDR_STATUS);
   wire [31:0]  rd_data   = (s_axi_araddr == ADDR_CSR)    ? csr_reg :
                            (s_axi_araddr == ADDR_IER)    ? ier_reg :
                            (s_axi_araddr == ADDR_STATUS) ? status_w :
                                                            32'h0000_0000;

   // Select decode; all other codes are no power-down
   wire sel_pd1  = (psel == SEL_PD1_EN) || (psel == SEL_PD1_ANY);
   wire sel_pd2  = (psel == SEL_PD2);
   wire sel_pd3  = (psel == SEL_PD3);
   wire sel_any  = sel_pd1 || sel_pd2 || sel_pd3;
   wire wake_irq = irq_enabled || (wake_any_reg && irq_nonenabled);
   wire do_isr   = irq_enabled && global_interrupt_allow && nonmaskable_interrupt_allow;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign pll_relocking = (state_reg == ST_RELOCK);
   assign ctrl          = ctrl_reg;
   assign isr_request   = isr_reg;
   assign resume_pulse  = resume_reg;

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
            if (sel_any && !emu_mask_reg && !wr_csr)
               state_next = ST_ENTRY;
         ST_ENTRY:
            if (!sel_any || emu_mask_reg)
               state_next = ST_RUN;
            else if (entry_cnt_reg == 4'(ENTRY_DELAY_CY - 1))
               state_next = sel_pd1 ? ST_GATED :
                            sel_pd2 ? ST_PLL_OUT : ST_PLL_IN;
         ST_GATED:
            if (emu_mask_reg)
               state_next = ST_RUN;
            else if (wake_irq)
               state_next = do_isr ? ST_SERVICE : ST_RUN;
         ST_SERVICE:
            if (isr_done)
               state_next = ST_RUN;
         ST_PLL_OUT:
            state_next = ST_PLL_OUT;
         ST_PLL_IN:
            state_next = ST_PLL_IN;
         ST_RELOCK:
            if (relock_cnt_reg == 32'(RELOCK_CYCLES - 1))
               state_next = ST_RUN;
         default:
            state_next = ST_RUN;
      endcase
   end

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   dpdc_ctrl_s ctrl_next;
   always_comb
   begin
      ctrl_next = '{default: 1'b1};
      ctrl_next.io_freeze     = 1'b0;
      ctrl_next.emu_spin_idle = 1'b0;
      case (state_next)
         ST_GATED:
         begin
            ctrl_next.cpu_clk_en = 1'b0;
            // Interrupt and DMA clocks stay on
            ctrl_next.irq_logic_clk_en = 1'b1;
            ctrl_next.dma_clk_en = 1'b1;
         end
         ST_PLL_OUT, ST_PLL_IN:
         begin
            // Clocks stop; flops hold state so contents survive
            ctrl_next.cpu_clk_en       = 1'b0;
            ctrl_next.irq_logic_clk_en = 1'b0;
            ctrl_next.dma_clk_en       = 1'b0;
            ctrl_next.pll_out_en       = 1'b0;
            ctrl_next.pll_in_en  = (state_next != ST_PLL_IN);
            // Async peripherals excluded
            ctrl_next.io_freeze     = 1'b1;
            ctrl_next.emu_spin_idle = 1'b1;
         end
         ST_RELOCK:
            ctrl_next.cpu_clk_en = 1'b0;
         default:
            ctrl_next.cpu_clk_en = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Clocked state
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Input halt survives a reset of any length; relock follows
         if (state_reg == ST_PLL_IN || state_reg == ST_RELOCK)
            state_reg <= ST_RELOCK;
         else
            state_reg <= ST_RUN;
         csr_reg <= CSR_RESET;
         ier_reg <= IER_RESET;
         entry_cnt_reg <= 4'h0;
         relock_cnt_reg <= 32'h0000_0000;
         emu_mask_reg <= 1'b0;
         wake_any_reg <= 1'b0;
         spin_seen_reg <= 1'b0;
         ctrl_reg <= '{cpu_clk_en: 1'b1, irq_logic_clk_en: 1'b1,
                       dma_clk_en: 1'b1, pll_out_en: 1'b1,
                       pll_in_en: 1'b1, io_freeze: 1'b0,
                       emu_spin_idle: 1'b0};
         isr_reg <= 1'b0;
         resume_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         entry_cnt_reg <= (state_reg == ST_ENTRY) ?
                          entry_cnt_reg + 4'h1 : 4'h0;
         relock_cnt_reg <= (state_reg == ST_RELOCK) ?
                           relock_cnt_reg + 32'h1 : 32'h0;
         // Mask holds until emulator reset or cable removal
         if (emu_reset || !emu_attached)
            emu_mask_reg <= 1'b0;
         else if (emu_attached)
            emu_mask_reg <= 1'b1;
         if (state_reg == ST_ENTRY)
            wake_any_reg <= (psel == SEL_PD1_ANY);
         if (emu_exec_cmd && ctrl_reg.emu_spin_idle)
            spin_seen_reg <= 1'b1;
         // Whole field taken in one write; no partial field update
         if (wr_csr)
            csr_reg <= (csr_reg & ~csr_wm) | (w_data_reg & csr_wm);
         if (wr_ier)
            ier_reg <= (ier_reg & ~ier_wm) | (w_data_reg & ier_wm);
         // Leaving mode clears field so CPU resumes running
         if ((state_reg == ST_GATED || state_reg == ST_SERVICE) &&
             state_next == ST_RUN)
            csr_reg[PSEL_LSB +: PSEL_W] <= 6'h00;
         isr_reg <= (state_next == ST_SERVICE);
         resume_reg <= (state_reg == ST_GATED || state_reg == ST_SERVICE)
                       && state_next == ST_RUN;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
         if (rd_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dpdc_power_down

// >>> dpdc_power_down_props.sv
`timescale 1ns/100ps
module dpdc_power_down_props
   import dpdc_pkg::*;
#(
   parameter int RELOCK_CYCLES = RELOCK_CY
)
(
   // Clock and bus
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   // Wake and emulator
   input wire logic        isr_done,
   input wire logic        irq_enabled,
   input wire logic        irq_nonenabled,
   input wire logic        emu_attached,
   input wire logic        emu_reset,
   input wire logic        emu_exec_cmd,
   // Power control
   input wire dpdc_ctrl_s  ctrl,
   input wire logic        isr_request,
   input wire logic        resume_pulse,
   input wire logic        pll_relocking
);
   logic [15:0] lock_cnt;
   wire  [5:0]  sel_w = s_axi_wdata[15:10];
   wire         deep = !ctrl.pll_out_en || !ctrl.pll_in_en;
   wire         csr_gate = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr == ADDR_CSR && s_axi_wstrb[1]
      && (sel_w == SEL_PD1_EN || sel_w == SEL_PD1_ANY);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Relock length, counted outside reset only
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !pll_relocking)
         lock_cnt <= 16'h0000;
      else
         lock_cnt <= lock_cnt + 16'h0001;
   end

   a_gate_entry_time:
   assert property (csr_gate && !emu_attached && ctrl.cpu_clk_en
      |-> ##[1:16] !ctrl.cpu_clk_en) else $error("gated entry late");
   a_gate_keeps_irq:
   assert property (!ctrl.cpu_clk_en && !deep && !pll_relocking
      |-> ctrl.irq_logic_clk_en && ctrl.dma_clk_en)
      else $error("gated mode stopped irq or dma clock");
   a_deep_only_reset:
   assert property ((irq_enabled || irq_nonenabled) && deep |=> deep)
      else $error("deep mode left without reset");
   a_freeze_deep:
   assert property (1'b1 |-> ctrl.io_freeze == deep)
      else $error("freeze does not match deep mode");
   a_spin_on_cmd:
   assert property (deep && emu_exec_cmd |-> ##[0:2] ctrl.emu_spin_idle)
      else $error("run command not spun in deep mode");
   a_spin_only_deep:
   assert property (ctrl.emu_spin_idle |-> deep)
      else $error("spin outside deep mode");
   a_emu_mask_all:
   assert property (emu_attached && !emu_reset && ctrl.cpu_clk_en && !deep
      && !pll_relocking |=> ctrl.cpu_clk_en && !deep)
      else $error("power-down entered with emulator attached");
   a_resume_after_isr:
   assert property (isr_request && isr_done |-> ##[1:3] resume_pulse)
      else $error("no resume after service routine");
   a_relock_length:
   assert property ($fell(pll_relocking) |-> lock_cnt >= RELOCK_CYCLES - 1
      && lock_cnt <= RELOCK_CYCLES + 1) else $error("relock wrong length");
endmodule // dpdc_power_down_props

bind dpdc_power_down dpdc_power_down_props #(.RELOCK_CYCLES(RELOCK_CYCLES))
   u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .isr_done,
   .irq_enabled, .irq_nonenabled, .emu_attached, .emu_reset, .emu_exec_cmd,
   .ctrl, .isr_request, .resume_pulse, .pll_relocking);

// >>> dpdc_cpu_model.sv
`timescale 1ns/100ps
module dpdc_cpu_model
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Service handshake
   input  wire logic       isr_request,
   input  wire logic [3:0] delay,
   output logic            isr_done
);
   logic [3:0] wait_reg;

   // Routine runs delay + 1 cycles before it reports done
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !isr_request)
      begin
         wait_reg <= 4'h0;
         isr_done <= 1'b0;
      end
      else
      begin
         wait_reg <= wait_reg + 4'h1;
         isr_done <= (wait_reg == delay);
      end
   end
endmodule // dpdc_cpu_model

// >>> dsp_power_down_control_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   fails++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module dsp_power_down_control_test
   import dpdc_pkg::*;
;
   localparam int RELOCK = 4;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, isr_done;
   logic        irq_enabled, irq_nonenabled, emu_attached, emu_reset;
   logic        emu_exec_cmd, isr_request, resume_pulse, pll_relocking;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
   logic [3:0]  s_axi_wstrb, dly;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [5:0]  code;
   dpdc_ctrl_s  ctrl;
   int          fails, n_compared, seed, k, i, t, n_res, n_isr;
   logic [5:0]  cd_t [6] = '{SEL_PD1_EN, SEL_PD1_ANY, SEL_PD1_ANY,
                             SEL_PD1_EN, SEL_PD1_EN, SEL_PD1_EN};
   logic [5:0]  en_t = 6'b110101;
   logic [5:0]  ge_t = 6'b101111;
   logic [5:0]  nm_t = 6'b011111;

   dpdc_power_down #(.RELOCK_CYCLES(RELOCK)) dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq_enabled, .irq_nonenabled, .isr_done, .emu_attached,
      .emu_reset, .emu_exec_cmd, .ctrl, .isr_request, .resume_pulse,
      .pll_relocking);
   dpdc_cpu_model u_cpu (.aclk, .aresetn, .isr_request, .delay(dly),
      .isr_done);

   always #25 aclk = ~aclk;
   always @(posedge aclk)
   begin
      n_res = n_res + int'(resume_pulse === 1'b1);
      n_isr = n_isr + int'(isr_request === 1'b1);
   end

   function automatic bit wakes(logic [5:0] c, logic e);
      return e || c == SEL_PD1_ANY;
   endfunction
   function automatic bit svc_exp(logic [5:0] c, logic e, logic g, logic m);
      return g && m && (e || c != SEL_PD1_ANY);
   endfunction

   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit done;
      done = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            done = 1;
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      if (!done)
         fails++;
   endtask

   task automatic rdr(input logic [7:0] a);
      bit done;
      done = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            done = 1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      if (!done)
         fails++;
   endtask

   task automatic reset_count(int c);
      aresetn <= 1'b0;
      repeat (c) @(posedge aclk);
      aresetn <= 1'b1;
      t = 0;
      repeat (RELOCK + 8) @(posedge aclk) t = t + int'(pll_relocking === 1);
   endtask

   task automatic wrap_up();
      if (fails == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
      {s_axi_rready, irq_enabled, irq_nonenabled, emu_attached} = 0;
      {emu_reset, emu_exec_cmd, s_axi_awaddr, s_axi_araddr} = 0;
      {s_axi_wdata, s_axi_wstrb, dly, fails, n_compared, n_res, n_isr} = 0;
      seed = 52;
      reset_count(20);
      `CHK("ctrl_rst", 7'h7C, ctrl)
      rdr(ADDR_EVENT);
      `CHK("unmapped", 34'h200000000, {resp, rd})
      wr(ADDR_EVENT, 32'h0000_0000);
      `CHK("bresp_bad", RESP_SLVERR, resp)
      for (i = 0; i < 6; i++)
      begin
         d = $random(seed);
         code = (i == 0) ? 6'h00 : {1'b0, d[30:26]};
         if (!(code inside {SEL_PD1_EN, SEL_PD1_ANY, SEL_PD2, SEL_PD3}))
         begin
            wr(ADDR_CSR, {d[31:16], code, d[9:0]});
            `CHK("bresp", RESP_OKAY, resp)
            repeat (16) @(posedge aclk);
            `CHK("reserved", 3'b111, ctrl[6:4] & {2'b11, ctrl.pll_out_en})
            rdr(ADDR_CSR);
            `CHK("csr", {16'h0, code, 9'h0, d[0]}, rd & CSR_WMASK)
         end
      end
      for (i = 0; i < 6; i++)
      begin
         wr(ADDR_IER, {30'h0, nm_t[i], 1'b0});
         wr(ADDR_CSR, {16'h0, cd_t[i], 9'h0, ge_t[i]});
         for (k = 0; k < 20 && ctrl.cpu_clk_en !== 1'b0; k++)
            @(posedge aclk);
         `CHK("entry", 1'b1, k <= 12)
         `CHK("gated", 2'b11, {ctrl.irq_logic_clk_en, ctrl.dma_clk_en})
         dly <= 4'($random(seed));
         n_res = 0;
         n_isr = 0;
         irq_enabled <= en_t[i];
         irq_nonenabled <= !en_t[i];
         repeat (30) @(posedge aclk);
         if (!wakes(cd_t[i], en_t[i]))
         begin
            `CHK("no_wake", 1'b0, ctrl.cpu_clk_en)
            irq_enabled <= 1'b1;
            repeat (30) @(posedge aclk);
         end
         `CHK("resumed", 2'b11, {ctrl.cpu_clk_en, n_res == 1})
         `CHK("service", svc_exp(cd_t[i], en_t[i], ge_t[i], nm_t[i]), n_isr > 0)
         irq_enabled <= 1'b0;
         irq_nonenabled <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      emu_attached <= 1'b1;
      wr(ADDR_CSR, {16'h0, SEL_PD1_EN, 10'h1});
      repeat (20) @(posedge aclk);
      `CHK("masked", 1'b1, ctrl.cpu_clk_en)
      wr(ADDR_CSR, 32'h0);
      emu_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      {emu_reset, emu_attached} <= 2'b00;
      for (i = 0; i < 2; i++)
      begin
         wr(ADDR_CSR, {16'h0, i == 0 ? SEL_PD2 : SEL_PD3, 10'h0});
         repeat (16) @(posedge aclk);
         `CHK("deep", 3'b101, {ctrl.pll_out_en, ctrl.pll_in_en, ctrl.io_freeze} ^ {1'b1, !i[0], 1'b0})
         {irq_enabled, irq_nonenabled, emu_exec_cmd} <= 3'b111;
         @(posedge aclk);
         emu_exec_cmd <= 1'b0;
         repeat (8) @(posedge aclk);
         `CHK("held", 2'b11, {ctrl.io_freeze, ctrl.emu_spin_idle})
         {irq_enabled, irq_nonenabled} <= 2'b00;
         reset_count(2);
         `CHK("relock", 1'b1, i == 0 ? t == 0 : t >= RELOCK && t <= RELOCK + 1)
         `CHK("woken", 7'h7C, ctrl)
      end
      wrap_up();
   end

   initial
   begin
      #(50 * 20000);
      fails++;
      wrap_up();
   end
endmodule // dsp_power_down_control_test
